/* File: core/asq_regs.svh */
// constants of the acquisition set sequencer: sizes, maps, reset values
// assumes inclusion by bare name from the package and the design files
`ifndef ASQ_REGS_SVH
`define ASQ_REGS_SVH
`define ASQ_NSET      8
`define ASQ_SET_W     3
`define ASQ_NFEAT     8
`define ASQ_FEAT_W    3
`define ASQ_FW        16
`define ASQ_NSRC      8
`define ASQ_SRC_W     3
`define ASQ_COND_W    2
`define ASQ_PATH_W    2
`define ASQ_PATH_ONLY 2'h0
// row i, bit j: the legal range of feature i depends on feature j
`define ASQ_DEP_MAP   64'h0102_0000_100a_0100
`define ASQ_AUTO_MASK 8'hc0
`define ASQ_MANUAL    16'h0000
`define ASQ_LIVE_RST  16'h0000
`define ASQ_SET_RST   3'h0
`endif

/* File: core/asq_pkg.sv */
// types shared by the sequencer modules
// assumes asq_regs.svh on the include path
`include "asq_regs.svh"
package asq_pkg;
  typedef enum logic [2:0]
  {
    ASQ_IDLE  = 3'h1,
    ASQ_SETUP = 3'h2,
    ASQ_RUN   = 3'h4
  } asq_state_t;
  typedef enum logic [`ASQ_COND_W-1:0]
  {
    ASQ_RISE = 2'h0,
    ASQ_FALL = 2'h1,
    ASQ_ANY  = 2'h2,
    ASQ_HIGH = 2'h3
  } asq_cond_t;
endpackage : asq_pkg

/* File: core/asq_class.sv */
// feature classifier: implied, fixed and forced masks from the direct mask
// assumes a stable direct mask; purely combinational
`timescale 1ns/1ns
`include "asq_regs.svh"
module asq_class (
  input  wire logic [`ASQ_NFEAT-1:0] i_direct,  // features sequenced directly
  output logic      [`ASQ_NFEAT-1:0] o_implied, // range follows a direct one
  output logic      [`ASQ_NFEAT-1:0] o_fixed,   // precondition of a sequenced one
  output logic      [`ASQ_NFEAT-1:0] o_forced   // automatic, held manual in run
);
  localparam logic [`ASQ_NFEAT*`ASQ_NFEAT-1:0] DEP  = `ASQ_DEP_MAP;
  localparam logic [`ASQ_NFEAT-1:0]            AUTO = `ASQ_AUTO_MASK;
  // preconditions chain: a precondition of a fixed feature is fixed as well
  wire [`ASQ_NFEAT-1:0] reach [`ASQ_NFEAT+1];
  wire [`ASQ_NFEAT-1:0] pre   [`ASQ_NFEAT];
  assign reach[0] = i_direct | o_implied;
  for (genvar i = 0; i < `ASQ_NFEAT; i++)
  begin : g_feat
    wire [`ASQ_NFEAT-1:0] row = DEP[i*`ASQ_NFEAT +: `ASQ_NFEAT];
    wire [`ASQ_NFEAT-1:0] col;
    for (genvar j = 0; j < `ASQ_NFEAT; j++)
    begin : g_col
      assign col[j] = DEP[j*`ASQ_NFEAT + i];
    end
    // one hop per level; eight levels cover the longest possible chain
    for (genvar k = 0; k < `ASQ_NFEAT; k++)
    begin : g_hop
      assign pre[k][i]       = |(col & reach[k]);
      assign reach[k+1][i]   = reach[k][i] | (pre[k][i] & ~AUTO[i]);
    end
    assign o_implied[i] = ~i_direct[i] & ~AUTO[i] & |(row & i_direct);
    // fixed only when no stronger class claims the feature
    assign o_fixed[i]   = ~i_direct[i] & ~AUTO[i] & ~o_implied[i]
                        & reach[`ASQ_NFEAT][i];
    assign o_forced[i]  = ~i_direct[i] & AUTO[i] & |i_direct;
  end
endmodule : asq_class

/* File: core/asq_trig.sv */
// transition trigger: edge or level detection on one selected source
// assumes sources already in the i_clock domain
`timescale 1ns/1ns
`include "asq_regs.svh"
module asq_trig (
  input  wire logic                  i_clock,   // system clock
  input  wire logic                  i_resetn,  // async reset, low
  input  wire logic                  i_enable,  // clock enable
  input  wire logic [`ASQ_NSRC-1:0]  i_src_vec, // all trigger sources
  input  wire logic [`ASQ_SRC_W-1:0] i_src_sel, // chosen source
  input  asq_pkg::asq_cond_t         i_cond,    // activation mode
  output logic                       o_fire     // transition condition met
);
  // history kept for every source so a source change cannot fake an edge
  logic [`ASQ_NSRC-1:0] prev_r;
  wire cur = i_src_vec[i_src_sel];
  wire old = prev_r[i_src_sel];
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      prev_r <= '0;
    else if (i_enable)
      prev_r <= i_src_vec;
  end
  always_comb
  begin
    case (i_cond)
      asq_pkg::ASQ_RISE: o_fire = cur & ~old;
      asq_pkg::ASQ_FALL: o_fire = ~cur & old;
      asq_pkg::ASQ_ANY:  o_fire = cur ^ old;
      default:           o_fire = cur;
    endcase
  end
endmodule : asq_trig

/* File: core/asq_sequencer.sv */
// acquisition set sequencer: set store, classification, locks, transitions
// assumes control strobes from same-clock logic; trigger lines are async
`timescale 1ns/1ns
`include "asq_regs.svh"
module asq_sequencer (
  input  wire logic                    i_clock,         // 50 MHz system clock
  input  wire logic                    i_resetn,        // async reset, low
  input  wire logic                    i_enable,        // clock enable
  input  wire logic [`ASQ_FEAT_W-1:0]  i_seq_feature_pick, // feature to enable
  input  wire logic                    i_direct_wr,     // direct enable strobe
  input  wire logic                    i_seq_feature_direct_on, // enable value
  input  wire logic                    i_setup_wr,      // setup mode strobe
  input  wire logic                    i_seq_setup_mode, // setup mode value
  input  wire logic                    i_set_pick_wr,   // set selector strobe
  input  wire logic [`ASQ_SET_W:0]     i_seq_set_pick,  // set selector value
  input  wire logic                    i_seq_set_store, // save pulse
  input  wire logic                    i_seq_set_recall, // load pulse
  input  wire logic [`ASQ_PATH_W-1:0]  i_seq_path_pick, // path selector
  input  wire logic                    i_src_wr,        // source strobe
  input  wire logic [`ASQ_SRC_W-1:0]   i_seq_transition_source, // source
  input  wire logic                    i_cond_wr,       // activation strobe
  input  wire logic [`ASQ_COND_W-1:0]  i_seq_transition_condition, // mode
  input  wire logic                    i_next_wr,       // next set strobe
  input  wire logic [`ASQ_SET_W:0]     i_seq_following_set, // next set
  input  wire logic                    i_first_wr,      // start set strobe
  input  wire logic [`ASQ_SET_W:0]     i_seq_first_set, // start set
  input  wire logic                    i_run_wr,        // run mode strobe
  input  wire logic                    i_seq_run_mode,  // run mode value
  input  wire logic                    i_live_wr,       // live feature write
  input  wire logic [`ASQ_FEAT_W-1:0]  i_live_idx,      // live feature index
  input  wire logic [`ASQ_FW-1:0]      i_live_data,     // live feature value
  input  wire logic [3:0]              i_int_events,    // internal events
  input  wire logic [3:0]              i_trig_lines,    // external lines
  output logic [`ASQ_NFEAT*`ASQ_FW-1:0] o_live,         // live feature values
  output logic [`ASQ_NFEAT-1:0]        o_live_lock,     // write-locked features
  output logic [`ASQ_NFEAT-1:0]        o_direct,        // direct enables
  output logic                         o_seq_setup_mode, // in setup
  output logic                         o_seq_setup_ok,  // setup checked good
  output logic [`ASQ_NSET-1:0]         o_seq_set_ok,    // per-set validity
  output logic [`ASQ_SET_W-1:0]        o_seq_set_pick,  // current selector
  output logic [`ASQ_SET_W-1:0]        o_active_set,    // active set
  output logic                         o_seq_run_mode,  // running
  output logic                         o_write_refused  // refused write pulse
);
  localparam int NS = `ASQ_NSET;
  localparam int NF = `ASQ_NFEAT;
  localparam int FW = `ASQ_FW;

  asq_pkg::asq_state_t state_r;
  asq_pkg::asq_state_t state_nxt;
  logic [NF-1:0]               direct_r;
  logic [NF-1:0]               implied_r;
  logic [NF-1:0]               fixed_r;
  logic [NF-1:0]               forced_r;
  logic [NF-1:0]               lock_r;
  logic [`ASQ_SET_W-1:0]       pick_r;
  logic [`ASQ_SET_W-1:0]       first_r;
  logic [`ASQ_SET_W-1:0]       active_r;
  logic [NF-1:0][FW-1:0]       live_r;
  logic [NS-1:0][NF-1:0][FW-1:0] bank_r;
  logic [NS-1:0][NF-1:0]       sig_r;
  logic [NS-1:0]               saved_r;
  logic [NS-1:0]               ok_r;
  logic [NS-1:0][`ASQ_SRC_W-1:0] src_r;
  logic [NS-1:0][`ASQ_COND_W-1:0] cond_r;
  logic [NS-1:0][`ASQ_SET_W-1:0] next_r;
  logic                        setup_ok_r;
  logic                        refuse_r;
  logic [3:0]                  lines_s1_r;
  logic [3:0]                  lines_s2_r;

  wire [NF-1:0] cls_implied;
  wire [NF-1:0] cls_fixed;
  wire [NF-1:0] cls_forced;
  wire          fire;

  asq_class u_class (
    .i_direct  (direct_r),
    .o_implied (cls_implied),
    .o_fixed   (cls_fixed),
    .o_forced  (cls_forced)
  );

  // external lines cross in through two flops before any use
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      lines_s1_r <= '0;
      lines_s2_r <= '0;
    end
    else if (i_enable)
    begin
      lines_s1_r <= i_trig_lines;
      lines_s2_r <= lines_s1_r;
    end
  end

  wire st_idle  = (state_r == asq_pkg::ASQ_IDLE);
  wire st_setup = (state_r == asq_pkg::ASQ_SETUP);
  wire st_run   = (state_r == asq_pkg::ASQ_RUN);

  wire [NF-1:0] seq_mask = direct_r | implied_r;
  wire [NF-1:0] run_mask = seq_mask | fixed_r | forced_r;

  asq_trig u_trig (
    .i_clock   (i_clock),
    .i_resetn  (i_resetn),
    .i_enable  (i_enable),
    .i_src_vec ({lines_s2_r, i_int_events}),
    .i_src_sel (src_r[active_r]),
    .i_cond    (asq_pkg::asq_cond_t'(cond_r[active_r])),
    .o_fire    (fire)
  );

  // command decode
  wire run_on_req   = i_run_wr & i_seq_run_mode;
  wire run_off_go   = i_run_wr & ~i_seq_run_mode & st_run;
  wire run_on_go    = run_on_req & st_idle & setup_ok_r;
  wire step_go      = st_run & fire & ~run_off_go;
  wire setup_on_go  = i_setup_wr & i_seq_setup_mode & st_idle;
  wire setup_off_go = i_setup_wr & ~i_seq_setup_mode & st_setup;
  wire direct_go    = i_direct_wr & st_idle;
  wire pick_go      = i_set_pick_wr & ~i_seq_set_pick[`ASQ_SET_W];
  wire path_bad     = (i_seq_path_pick != `ASQ_PATH_ONLY);
  wire prog_ok      = ~path_bad & ~st_run;
  wire src_go       = i_src_wr & prog_ok;
  wire cond_go      = i_cond_wr & prog_ok;
  wire next_go      = i_next_wr & prog_ok & ~i_seq_following_set[`ASQ_SET_W];
  wire first_go     = i_first_wr & ~st_run & ~i_seq_first_set[`ASQ_SET_W];
  wire store_go     = i_seq_set_store & ~st_run;
  wire recall_go    = i_seq_set_recall & ~st_run & ok_r[pick_r]
                    & ~run_on_req;
  wire live_go      = i_live_wr & ~lock_r[i_live_idx];

  wire refuse_any = (i_live_wr & ~live_go) | (i_set_pick_wr & ~pick_go)
                  | (i_src_wr & ~src_go) | (i_cond_wr & ~cond_go)
                  | (i_next_wr & ~next_go) | (i_first_wr & ~first_go)
                  | (i_direct_wr & ~direct_go) | (i_seq_set_store & ~store_go)
                  | (i_seq_set_recall & ~recall_go) | (i_setup_wr & st_run)
                  | (run_on_req & ~run_on_go);

  // one load path shared by run entry, transitions and recall
  wire [`ASQ_SET_W-1:0] next_of_act = next_r[active_r];
  wire [`ASQ_SET_W-1:0] load_idx = run_on_go ? first_r
                                  : step_go ? next_of_act
                                  : pick_r;
  wire                  load_go  = run_on_go | step_go | recall_go;
  wire [NF-1:0]         load_sig = sig_r[load_idx];
  wire                  force_on = st_run | run_on_go;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      asq_pkg::ASQ_IDLE:
      begin
        if (setup_on_go)
          state_nxt = asq_pkg::ASQ_SETUP;
        else if (run_on_go)
          state_nxt = asq_pkg::ASQ_RUN;
      end
      asq_pkg::ASQ_SETUP:
      begin
        if (setup_off_go)
          state_nxt = asq_pkg::ASQ_IDLE;
      end
      asq_pkg::ASQ_RUN:
      begin
        if (run_off_go)
          state_nxt = asq_pkg::ASQ_IDLE;
      end
      default: state_nxt = asq_pkg::ASQ_IDLE;
    endcase
  end

  // classes are captured only on setup entry, so direct changes need re-entry
  wire [NF-1:0] fixed_nxt = setup_on_go ? cls_fixed : fixed_r;
  wire [NF-1:0] lock_nxt  =
      (state_nxt == asq_pkg::ASQ_SETUP) ? fixed_nxt
    : (state_nxt == asq_pkg::ASQ_RUN)   ? run_mask
    : '0;

  // configuration check: start set valid and every valid set leads to one
  wire [NS-1:0] chain_ok;
  wire          setup_ok_calc = (&chain_ok) & ok_r[first_r];

  wire [NF-1:0][FW-1:0] live_nxt;
  wire [NF-1:0]         forced_bad;

  for (genvar f = 0; f < NF; f++)
  begin : g_live
    wire hit = live_go & (i_live_idx == `ASQ_FEAT_W'(f));
    assign live_nxt[f] = (force_on & forced_r[f]) ? `ASQ_MANUAL
                       : (load_go & load_sig[f]) ? bank_r[load_idx][f]
                       : hit ? i_live_data
                       : live_r[f];
    assign forced_bad[f] = forced_r[f] & (live_r[f] != `ASQ_MANUAL);
  end

  for (genvar s = 0; s < NS; s++)
  begin : g_set
    wire sel = (pick_r == `ASQ_SET_W'(s));
    wire saved_nxt = saved_r[s] | (store_go & sel);
    wire [NF-1:0] sig_nxt = (store_go & sel) ? seq_mask : sig_r[s];
    assign chain_ok[s] = ~ok_r[s] | ok_r[next_r[s]];
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        bank_r[s]  <= '0;
        sig_r[s]   <= '0;
        saved_r[s] <= 1'b0;
        ok_r[s]    <= 1'b0;
      end
      else if (i_enable & store_go)
      begin
        if (sel)
          bank_r[s] <= live_r;
        sig_r[s]   <= sig_nxt;
        saved_r[s] <= saved_nxt;
        ok_r[s]    <= saved_nxt & (sig_nxt == seq_mask) & |seq_mask;
      end
    end
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        src_r[s]  <= '0;
        cond_r[s] <= '0;
        next_r[s] <= `ASQ_SET_RST;
      end
      else if (i_enable & sel)
      begin
        if (src_go)
          src_r[s] <= i_seq_transition_source;
        if (cond_go)
          cond_r[s] <= i_seq_transition_condition;
        if (next_go)
          next_r[s] <= i_seq_following_set[`ASQ_SET_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= asq_pkg::ASQ_IDLE;
      lock_r  <= '0;
      live_r  <= {NF{`ASQ_LIVE_RST}};
    end
    else if (i_enable)
    begin
      state_r <= state_nxt;
      lock_r  <= lock_nxt;
      live_r  <= live_nxt;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      direct_r  <= '0;
      implied_r <= '0;
      fixed_r   <= '0;
      forced_r  <= '0;
    end
    else if (i_enable)
    begin
      if (direct_go)
        direct_r[i_seq_feature_pick] <= i_seq_feature_direct_on;
      if (setup_on_go)
      begin
        implied_r <= cls_implied;
        fixed_r   <= cls_fixed;
        forced_r  <= cls_forced;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pick_r     <= `ASQ_SET_RST;
      first_r    <= `ASQ_SET_RST;
      active_r   <= `ASQ_SET_RST;
      setup_ok_r <= 1'b0;
      refuse_r   <= 1'b0;
    end
    else if (i_enable)
    begin
      if (pick_go)
        pick_r <= i_seq_set_pick[`ASQ_SET_W-1:0];
      if (first_go)
        first_r <= i_seq_first_set[`ASQ_SET_W-1:0];
      if (run_on_go | step_go)
        active_r <= load_idx;
      // a new start set or setup entry voids the earlier check
      if (setup_off_go)
        setup_ok_r <= setup_ok_calc;
      else if (setup_on_go | first_go)
        setup_ok_r <= 1'b0;
      refuse_r <= refuse_any;
    end
  end

  assign o_live           = live_r;
  assign o_live_lock      = lock_r;
  assign o_direct         = direct_r;
  assign o_seq_setup_mode = state_r[1];
  assign o_seq_run_mode   = state_r[2];
  assign o_seq_setup_ok   = setup_ok_r;
  assign o_seq_set_ok     = ok_r;
  assign o_seq_set_pick   = pick_r;
  assign o_active_set     = active_r;
  assign o_write_refused  = refuse_r;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  chk_store_copy: assert property (i_enable & store_go |=>
    bank_r[$past(pick_r)] == $past(live_r))
    else $error("save did not copy live values");
  chk_fixed_lock: assert property ((st_setup | st_run) |->
    (lock_r & fixed_r) == fixed_r)
    else $error("fixed feature left writable");
  chk_implied_lock: assert property (
    (st_run |-> (lock_r & implied_r) == implied_r)
    and (st_setup |-> (lock_r & implied_r) == '0))
    else $error("implied lock wrong");
  chk_forced_manual: assert property (st_run |-> forced_bad == '0)
    else $error("forced feature not manual in run");
  chk_forced_open: assert property (st_setup |-> (lock_r & forced_r) == '0)
    else $error("forced feature locked in setup");
  chk_nonseq_free: assert property ((lock_r & ~run_mask) == '0)
    else $error("non-sequenced feature locked");
  chk_run_start: assert property (i_enable & run_on_go |=>
    st_run && active_r == $past(first_r) && lock_r == run_mask)
    else $error("run entry wrong");
  chk_step_next: assert property (i_enable & step_go |=>
    active_r == $past(next_of_act))
    else $error("transition went to wrong set");
  chk_pick_range: assert property (i_enable & i_set_pick_wr
    & i_seq_set_pick[`ASQ_SET_W] |=> $stable(pick_r) && o_write_refused)
    else $error("out of range set index taken");
  chk_run_ignore: assert property (i_enable & st_run & i_seq_set_store
    |=> $stable(bank_r) && o_write_refused)
    else $error("save taken while running");
  chk_setup_check: assert property (i_enable & setup_off_go |=>
    o_seq_setup_ok == $past(setup_ok_calc) && st_idle)
    else $error("setup check not reported");
  chk_off_keep: assert property (i_enable & run_off_go & ~i_live_wr |=>
    $stable(live_r) && st_idle)
    else $error("run off changed live values");

  cov_run_entry: cover property (i_enable & run_on_go);
  cov_step: cover property (st_run ##1 i_enable & step_go);
  cov_store_recall: cover property (i_enable & store_go ##[1:20] i_enable & recall_go);
endmodule : asq_sequencer

/* File: verification/tb_asq_sequencer.sv */
// testbench for the acquisition set sequencer: classes, locks, set store, stepping
// assumes asq_pkg and asq_sequencer compiled first; the bench drives every port
`timescale 1ns/1ns
module tb_asq_sequencer;
  localparam int DIR = 0, SETUP = 1, PICK = 2, STORE = 3, RECALL = 4, SRC = 5;
  localparam int COND = 6, NEXT = 7, FIRST = 8, RUN = 9, LIVE = 10;
  logic         i_clock;
  logic         i_resetn;
  logic         en;          // clock enable
  logic [10:0]  st;          // one strobe per command kind
  logic [15:0]  d;           // shared value field, path selector in [15:14]
  logic [2:0]   ix;          // feature index
  logic [3:0]   ev;          // internal events
  logic [3:0]   ln;          // external lines
  logic [127:0] o_live;
  logic [7:0]   o_live_lock;
  logic [7:0]   o_direct;
  logic         o_seq_setup_mode;
  logic         o_seq_setup_ok;
  logic [7:0]   o_seq_set_ok;
  logic [2:0]   o_seq_set_pick;
  logic [2:0]   o_active_set;
  logic         o_seq_run_mode;
  logic         o_write_refused;
  int           fails = 0;
  int           comparisons = 0;
  int           cycles = 0;

  asq_sequencer u_dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_enable(en),
    .i_seq_feature_pick(ix), .i_direct_wr(st[DIR]), .i_seq_feature_direct_on(d[0]),
    .i_setup_wr(st[SETUP]), .i_seq_setup_mode(d[0]), .i_set_pick_wr(st[PICK]),
    .i_seq_set_pick(d[3:0]), .i_seq_set_store(st[STORE]), .i_seq_set_recall(st[RECALL]),
    .i_seq_path_pick(d[15:14]), .i_src_wr(st[SRC]), .i_seq_transition_source(d[2:0]),
    .i_cond_wr(st[COND]), .i_seq_transition_condition(d[1:0]), .i_next_wr(st[NEXT]),
    .i_seq_following_set(d[3:0]), .i_first_wr(st[FIRST]), .i_seq_first_set(d[3:0]),
    .i_run_wr(st[RUN]), .i_seq_run_mode(d[0]), .i_live_wr(st[LIVE]), .i_live_idx(ix),
    .i_live_data(d), .i_int_events(ev), .i_trig_lines(ln), .o_live(o_live),
    .o_live_lock(o_live_lock), .o_direct(o_direct), .o_seq_setup_mode(o_seq_setup_mode),
    .o_seq_setup_ok(o_seq_setup_ok), .o_seq_set_ok(o_seq_set_ok),
    .o_seq_set_pick(o_seq_set_pick), .o_active_set(o_active_set),
    .o_seq_run_mode(o_seq_run_mode), .o_write_refused(o_write_refused)
  );

  task automatic conclude();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // refusal pulse must follow the strobe edge and last exactly one cycle
  task automatic cmd(input int s, input logic [15:0] v, input logic [2:0] x,
                     input logic rexp);
    logic r;
    @(posedge i_clock);
    st <= 11'h1 << s;
    d <= v;
    ix <= x;
    @(posedge i_clock);
    st <= '0;
    #1 r = o_write_refused;
    @(posedge i_clock);
    #1 chk({14'h0, r, o_write_refused}, {14'h0, rexp, 1'b0});
  endtask : cmd

  function automatic logic [15:0] live(input int f);
    return o_live[16*f +: 16];
  endfunction : live

  initial
  begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // a hang counts as a mismatch
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      conclude();
    end
  end

  initial
  begin
    i_resetn = 1'b0;
    st = '0;
    d = '0;
    ix = '0;
    ev = '0;
    ln = '0;
    en = 1'b1;
    repeat (5) @(posedge i_clock);
    i_resetn <= 1'b1;
    #1 chk({o_seq_setup_mode, o_seq_run_mode, o_direct, |o_live, o_seq_setup_ok,
            o_write_refused}, 16'h0000);
    cmd(LIVE, 16'h0055, 3'h5, 1'b0);
    cmd(DIR, 16'h0001, 3'h1, 1'b0);
    chk(o_direct, 16'h0002);
    cmd(SETUP, 16'h0001, 3'h0, 1'b0);
    chk(o_live_lock, 16'h0019);
    cmd(LIVE, 16'h1111, 3'h0, 1'b1);
    cmd(LIVE, 16'h0abc, 3'h6, 1'b0);
    cmd(PICK, 16'h0008, 3'h0, 1'b1);
    for (int s = 0; s < 2; s++)
    begin
      cmd(PICK, 16'(s), 3'h0, 1'b0);
      cmd(LIVE, 16'h0100 + 16'(17 * s), 3'h1, 1'b0);
      cmd(LIVE, 16'h0200 + 16'(34 * s), 3'h2, 1'b0);
      cmd(STORE, 16'h0000, 3'h0, 1'b0);
      chk(o_seq_set_ok, (s == 1) ? 16'h0003 : 16'h0001);
      cmd(NEXT, 16'(1 - s), 3'h0, 1'b0);
      cmd(SRC, 16'h0004, 3'h0, 1'b0);
      cmd(COND, 16'h0000, 3'h0, 1'b0);
    end
    cmd(NEXT, 16'h4001, 3'h0, 1'b1);
    cmd(NEXT, 16'h0008, 3'h0, 1'b1);
    cmd(FIRST, 16'h0000, 3'h0, 1'b0);
    cmd(PICK, 16'h0005, 3'h0, 1'b0);
    cmd(RECALL, 16'h0000, 3'h0, 1'b1);
    cmd(PICK, 16'h0000, 3'h0, 1'b0);
    cmd(RECALL, 16'h0000, 3'h0, 1'b0);
    chk(live(1), 16'h0100);
    cmd(SETUP, 16'h0000, 3'h0, 1'b0);
    chk({15'h0, o_seq_setup_ok}, 16'h0001);
    cmd(RUN, 16'h0001, 3'h0, 1'b0);
    chk({o_seq_run_mode, 1'b0, o_active_set}, 16'h0010);
    chk(live(1), 16'h0100);
    chk(live(6), 16'h0000);
    chk(live(5), 16'h0055);
    chk(o_live_lock, 16'h00df);
    cmd(LIVE, 16'h7777, 3'h1, 1'b1);
    cmd(LIVE, 16'h0066, 3'h5, 1'b0);
    cmd(STORE, 16'h0000, 3'h0, 1'b1);
    cmd(RECALL, 16'h0000, 3'h0, 1'b1);
    cmd(SETUP, 16'h0001, 3'h0, 1'b1);
    @(posedge i_clock);
    ln <= 4'h1;
    repeat (8) @(posedge i_clock);
    #1 chk(o_active_set, 16'h0001);
    chk(live(1), 16'h0111);
    chk(live(2), 16'h0222);
    @(posedge i_clock);
    ln <= 4'h0;
    cmd(RUN, 16'h0000, 3'h0, 1'b0);
    chk(o_live_lock, 16'h0000);
    chk(live(1), 16'h0111);
    // one-cycle event pulse: any edge steps twice, the others once
    for (int c = 0; c < 4; c++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        cmd(PICK, 16'(s), 3'h0, 1'b0);
        cmd(SRC, 16'h0000, 3'h0, 1'b0);
        cmd(COND, 16'(c), 3'h0, 1'b0);
      end
      cmd(RUN, 16'h0001, 3'h0, 1'b0);
      chk(o_active_set, 16'h0000);
      @(posedge i_clock);
      ev <= 4'h1;
      @(posedge i_clock);
      ev <= 4'h0;
      repeat (6) @(posedge i_clock);
      #1 chk(o_active_set, (c == 2) ? 16'h0000 : 16'h0001);
      cmd(RUN, 16'h0000, 3'h0, 1'b0);
    end
    // clock enable low: a legal selector write must leave no trace
    @(posedge i_clock);
    en <= 1'b0;
    cmd(PICK, 16'h0004, 3'h0, 1'b0);
    chk(o_seq_set_pick, 16'h0001);
    @(posedge i_clock);
    en <= 1'b1;
    cmd(LIVE, 16'h0999, 3'h1, 1'b0);
    cmd(PICK, 16'h0001, 3'h0, 1'b0);
    cmd(RECALL, 16'h0000, 3'h0, 1'b0);
    chk(live(1), 16'h0111);
    // fixed feature changed outside setup, then setup re-entered
    cmd(LIVE, 16'h1234, 3'h0, 1'b0);
    cmd(SETUP, 16'h0001, 3'h0, 1'b0);
    cmd(LIVE, 16'h4321, 3'h0, 1'b1);
    chk(live(0), 16'h1234);
    cmd(SETUP, 16'h0000, 3'h0, 1'b0);
    chk({15'h0, o_seq_setup_ok}, 16'h0001);
    // a wider direct set makes the older set 1 invalid on the next save
    cmd(DIR, 16'h0001, 3'h5, 1'b0);
    cmd(SETUP, 16'h0001, 3'h0, 1'b0);
    chk(o_live_lock, 16'h0019);
    cmd(PICK, 16'h0000, 3'h0, 1'b0);
    cmd(STORE, 16'h0000, 3'h0, 1'b0);
    chk(o_seq_set_ok, 16'h0001);
    conclude();
  end
endmodule : tb_asq_sequencer
